// ---- inc/core_irq_params.svh ----
// Offsets, field positions, reset values for the interrupt state and counter divider block
`ifndef CORE_IRQ_PARAMS_SVH
`define CORE_IRQ_PARAMS_SVH

// ==========================================
// Register offsets, one set per channel
`define CORE0_STATE_CH1   9'h10F
`define CORE1_STATE_CH1   9'h110
`define DIVIDER_CH1       9'h111
`define CORE0_STATE_CH2   9'h12F
`define CORE1_STATE_CH2   9'h130
`define DIVIDER_CH2       9'h131
`define CORE0_STATE_CH3   9'h14F
`define CORE1_STATE_CH3   9'h150
`define DIVIDER_CH3       9'h151

// ==========================================
// Field positions of the status word
`define STATE_BUSY_BIT    13
`define STATE_SRC_MSB     12
`define STATE_SRC_LSB     10
`define STATE_IRET_MSB    9
`define STATE_IRET_LSB    0

// ==========================================
// Widths and reset values
`define REG_ADDR_W        9
`define REG_DATA_W        16
`define DIV_FIELD_W       4
`define DIV_FIELDS        4
`define DIV_RESET         16'h0000
`define STATE_RESET       16'h0000
`define RDATA_UNMAPPED    16'h0000

`endif

// ---- inc/core_irq_pkg.sv ----
// Types shared by the interrupt state and counter divider block
package core_irq_pkg;

  // Interrupt source codes
  typedef enum logic [2:0] {
    SRC_START_RISE = 3'h0,
    SRC_DRV_OFF    = 3'h1,
    SRC_AUTO_DIAG  = 3'h2,
    SRC_START_FALL = 3'h3,
    SRC_SOFT0      = 3'h4,
    SRC_SOFT1      = 3'h5,
    SRC_SOFT2      = 3'h6,
    SRC_SOFT3      = 3'h7
  } irq_src_t;

  // Interrupt entry and exit report from one sequencer core
  typedef struct packed {
    logic       enter;
    logic       leave;
    irq_src_t   source;
    logic       cond_instr;
    logic       cond_met;
    logic [9:0] seq_addr;
    logic [9:0] branch_addr;
  } core_event_t;

  // Status word layout
  typedef struct packed {
    logic [1:0] reserved;
    logic       busy;
    irq_src_t   source;
    logic [9:0] iret;
  } state_word_t;

  // Divider register layout, msb first
  typedef struct packed {
    logic [3:0] b_fourth;
    logic [3:0] b_third;
    logic [3:0] a_fourth;
    logic [3:0] a_third;
  } divider_fields_t;

  // Start edge interrupt enables, index 0 core a, index 1 core b
  typedef struct packed {
    logic [1:0] rise_en;
    logic [1:0] fall_en;
  } start_irq_cfg_t;

endpackage

// ---- hdl/core_irq_state.sv ----
// Interrupt state words and counter tick dividers for one channel of two sequencer cores
`timescale 1ns/10ps
`include "core_irq_params.svh"

module core_irq_state #(
  parameter int CHANNEL = 1
) (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic [`REG_ADDR_W-1:0]       reg_addr,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  input  wire logic [`REG_DATA_W-1:0]       reg_wdata,
  output logic      [`REG_DATA_W-1:0]       reg_rdata,
  output logic                              reg_ack,
  input  wire core_irq_pkg::core_event_t    core_a_evt,
  input  wire core_irq_pkg::core_event_t    core_b_evt,
  input  wire core_irq_pkg::start_irq_cfg_t start_cfg,
  input  wire logic                         start_pin,
  input  wire logic                         core_tick,
  output logic      [`DIV_FIELDS-1:0]       count_tick,
  output logic      [1:0]                   soft_irq_req
);
  import core_irq_pkg::*;

  // ==========================================
  // Address selection for this channel
  localparam logic [`REG_ADDR_W-1:0] STATE_A_ADDR =
    (CHANNEL == 3) ? `CORE0_STATE_CH3 : (CHANNEL == 2) ? `CORE0_STATE_CH2 : `CORE0_STATE_CH1;
  localparam logic [`REG_ADDR_W-1:0] STATE_B_ADDR =
    (CHANNEL == 3) ? `CORE1_STATE_CH3 : (CHANNEL == 2) ? `CORE1_STATE_CH2 : `CORE1_STATE_CH1;
  localparam logic [`REG_ADDR_W-1:0] DIV_ADDR =
    (CHANNEL == 3) ? `DIVIDER_CH3 : (CHANNEL == 2) ? `DIVIDER_CH2 : `DIVIDER_CH1;

  core_event_t                      evt [2];
  state_word_t                      state_q [2];
  divider_fields_t                  div_q;
  logic [`REG_DATA_W-1:0]           rdata_q;
  logic                             ack_q;
  logic [`DIV_FIELD_W-1:0]          field   [`DIV_FIELDS];
  logic [`DIV_FIELD_W-1:0]          last_q  [`DIV_FIELDS];
  logic [`DIV_FIELD_W-1:0]          cnt_q   [`DIV_FIELDS];
  logic [`DIV_FIELDS-1:0]           tick_q;
  logic                             start_meta_q;
  logic                             start_sync_q;
  logic                             start_prev_q;
  logic                             start_rise;
  logic                             start_fall;
  logic [1:0]                       soft_q;
  logic                             div_write;

  assign evt[0] = core_a_evt;
  assign evt[1] = core_b_evt;

  // ==========================================
  // Interrupt status words, one per core
  for (genvar c = 0; c < 2; c++) begin : g_core
    // Entry wins over exit in the same cycle; host writes never reach here
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        state_q[c] <= `STATE_RESET;
      end else if (evt[c].enter) begin
        state_q[c].reserved <= 2'h0;
        state_q[c].busy     <= 1'b1;
        state_q[c].source   <= evt[c].source;
        // Feedback sampled in the request cycle picks the branch
        state_q[c].iret     <= (evt[c].cond_instr && evt[c].cond_met) ?
                               evt[c].branch_addr : evt[c].seq_addr;
      end else if (evt[c].leave) begin
        state_q[c] <= `STATE_RESET;
      end
    end

    state_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
      evt[c].enter |=> state_q[c].busy)
      else $error("status busy bit not set on entry");
    state_source_a: assert property (@(posedge clk) disable iff (!rst_n)
      evt[c].enter |=> state_q[c].source == $past(evt[c].source))
      else $error("status source not captured");
    iret_plain_a: assert property (@(posedge clk) disable iff (!rst_n)
      evt[c].enter && !evt[c].cond_instr |=> state_q[c].iret == $past(evt[c].seq_addr))
      else $error("return address not sequential");
    iret_cond_a: assert property (@(posedge clk) disable iff (!rst_n)
      evt[c].enter && evt[c].cond_instr |=>
        state_q[c].iret == ($past(evt[c].cond_met) ?
                            $past(evt[c].branch_addr) : $past(evt[c].seq_addr)))
      else $error("conditional return address wrong");
    state_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      evt[c].leave && !evt[c].enter |=> state_q[c] == `STATE_RESET)
      else $error("status word not cleared on exit");
    reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      state_q[c].reserved == 2'h0 && (state_q[c].busy || state_q[c] == `STATE_RESET))
      else $error("reserved bits or idle word not zero");

    // Word stands between events; host writes never move it
    state_stand_a: assert property (@(posedge clk) disable iff (!rst_n)
      !evt[c].enter && !evt[c].leave |=> $stable(state_q[c]))
      else $error("status word moved without an event");
    enter_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
      evt[c].enter && evt[c].leave |=> state_q[c].busy)
      else $error("exit beat entry in one cycle");
    idle_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
      evt[c].leave && !evt[c].enter |=> !state_q[c].busy)
      else $error("busy bit left set after exit");

    // Return address picked by the feedback seen at entry
    iret_met_a: assert property (@(posedge clk) disable iff (!rst_n)
      evt[c].enter && evt[c].cond_instr && evt[c].cond_met
        |=> state_q[c].iret == $past(evt[c].branch_addr))
      else $error("met condition did not take branch address");
    iret_unmet_a: assert property (@(posedge clk) disable iff (!rst_n)
      evt[c].enter && !(evt[c].cond_instr && evt[c].cond_met)
        |=> state_q[c].iret == $past(evt[c].seq_addr))
      else $error("return address not the next address");

    // Each word read back at its own address
    read_state_a: assert property (@(posedge clk) disable iff (!rst_n)
      reg_rd && reg_addr == ((c == 0) ? STATE_A_ADDR : STATE_B_ADDR)
        |=> reg_rdata == $past(state_q[c]))
      else $error("status word read back wrong");
  end

  cores_apart_a: assert property (@(posedge clk) disable iff (!rst_n)
    evt[0].enter && !evt[1].enter && !evt[1].leave |=> $stable(state_q[1]))
    else $error("core b status moved with core a");
  core_a_kept_a: assert property (@(posedge clk) disable iff (!rst_n)
    evt[1].enter && !evt[0].enter && !evt[0].leave |=> $stable(state_q[0]))
    else $error("core a status moved with core b");

  // Synchronous reset clears every output and word
  reset_bus_a: assert property (@(posedge clk)
    !rst_n |=> !reg_ack && reg_rdata == `RDATA_UNMAPPED)
    else $error("register port not idle after reset");
  reset_out_a: assert property (@(posedge clk)
    !rst_n |=> count_tick == 4'h0 && soft_irq_req == 2'h0)
    else $error("tick or request out of reset");
  reset_state_a: assert property (@(posedge clk)
    !rst_n |=> state_q[0] == `STATE_RESET && state_q[1] == `STATE_RESET)
    else $error("status words not clear after reset");

  // ==========================================
  // Register port
  assign div_write = reg_wr && (reg_addr == DIV_ADDR);

  // Divider register; status words are read only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_q <= `DIV_RESET;
    end else if (div_write) begin
      div_q <= reg_wdata;
    end
  end

  // Read data and acknowledge, one cycle after the request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= `RDATA_UNMAPPED;
      ack_q   <= 1'b0;
    end else begin
      ack_q <= reg_wr || reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          STATE_A_ADDR: rdata_q <= state_q[0];
          STATE_B_ADDR: rdata_q <= state_q[1];
          DIV_ADDR:     rdata_q <= div_q;
          default:      rdata_q <= `RDATA_UNMAPPED;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_ack   = ack_q;

  div_reset_a: assert property (@(posedge clk)
    !rst_n |=> div_q == `DIV_RESET)
    else $error("divider fields not zero after reset");
  write_ignored_a: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == STATE_A_ADDR && !evt[0].enter && !evt[0].leave
      |=> $stable(state_q[0]))
    else $error("host write changed a status word");
  read_back_a: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == DIV_ADDR && !reg_wr |=> reg_ack && reg_rdata == $past(div_q))
    else $error("divider read back wrong");

  // Acknowledge answers every strobe, once
  ack_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr || reg_rd) |=> reg_ack)
    else $error("strobe not acknowledged");
  ack_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    !reg_wr && !reg_rd |=> !reg_ack)
    else $error("acknowledge without a strobe");

  // Read data stands until the next read; unmapped reads give zero
  rdata_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr != STATE_A_ADDR && reg_addr != STATE_B_ADDR && reg_addr != DIV_ADDR
      |=> reg_rdata == `RDATA_UNMAPPED)
    else $error("unmapped read not zero");
  wr_rd_old_a: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_rd && reg_addr == DIV_ADDR |=> reg_rdata == $past(div_q))
    else $error("same cycle read did not return old value");

  // Divider changes only on a write to its own address
  div_store_a: assert property (@(posedge clk) disable iff (!rst_n)
    div_write |=> div_q == $past(reg_wdata))
    else $error("divider write not stored");
  div_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !div_write |=> $stable(div_q))
    else $error("divider moved without a write");

  // ==========================================
  // Counter tick dividers
  assign field[0] = div_q.a_third;
  assign field[1] = div_q.a_fourth;
  assign field[2] = div_q.b_third;
  assign field[3] = div_q.b_fourth;

  for (genvar i = 0; i < `DIV_FIELDS; i++) begin : g_div
    // Count core ticks; a field change restarts the count, tick held low
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        cnt_q[i]  <= 4'h0;
        last_q[i] <= 4'h0;
        tick_q[i] <= 1'b0;
      end else begin
        last_q[i] <= field[i];
        tick_q[i] <= 1'b0;
        if (field[i] != last_q[i]) begin
          cnt_q[i] <= 4'h0;
        end else if (core_tick) begin
          if (cnt_q[i] == field[i]) begin
            cnt_q[i]  <= 4'h0;
            tick_q[i] <= 1'b1;
          end else begin
            cnt_q[i] <= cnt_q[i] + 4'h1;
          end
        end
      end
    end

    div_ratio_a: assert property (@(posedge clk) disable iff (!rst_n)
      core_tick && field[i] == last_q[i] && cnt_q[i] == field[i] |=> tick_q[i])
      else $error("divider missed its tick");
    div_source_a: assert property (@(posedge clk) disable iff (!rst_n)
      tick_q[i] |-> $past(core_tick))
      else $error("tick without a core tick");
    div_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
      field[i] != last_q[i] |=> cnt_q[i] == 4'h0 && !tick_q[i])
      else $error("divider not restarted on change");

    // Count stays in range and steps once per core tick
    count_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
      field[i] == last_q[i] |-> cnt_q[i] <= field[i])
      else $error("divider count past its field");
    tick_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
      !core_tick && field[i] == last_q[i] |=> $stable(cnt_q[i]) && !tick_q[i])
      else $error("divider moved without a core tick");
    tick_step_a: assert property (@(posedge clk) disable iff (!rst_n)
      core_tick && field[i] == last_q[i] && cnt_q[i] != field[i]
        |=> cnt_q[i] == $past(cnt_q[i]) + 4'h1 && !tick_q[i])
      else $error("divider count did not step");
    tick_single_a: assert property (@(posedge clk) disable iff (!rst_n)
      tick_q[i] && field[i] != 4'h0 |=> !tick_q[i])
      else $error("divided tick wider than one cycle");
    div_rewrite_a: assert property (@(posedge clk) disable iff (!rst_n)
      div_write && reg_wdata[i*4 +: 4] != field[i]
        |=> ##1 cnt_q[i] == 4'h0 && !tick_q[i])
      else $error("written field did not restart its divider");
  end

  assign count_tick = tick_q;

  // ==========================================
  // Start input synchroniser and edge interrupts
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      start_meta_q <= 1'b0;
      start_sync_q <= 1'b0;
      start_prev_q <= 1'b0;
    end else begin
      start_meta_q <= start_pin;
      start_sync_q <= start_meta_q;
      start_prev_q <= start_sync_q;
    end
  end

  assign start_rise = start_sync_q && !start_prev_q;
  assign start_fall = !start_sync_q && start_prev_q;

  // One-cycle request per enabled edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      soft_q <= 2'h0;
    end else begin
      soft_q <= ({2{start_rise}} & start_cfg.rise_en) |
                ({2{start_fall}} & start_cfg.fall_en);
    end
  end

  assign soft_irq_req = soft_q;

  soft_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
    start_rise && start_cfg.rise_en[0] |=> soft_irq_req[0])
    else $error("rising start edge lost");
  soft_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    !start_rise && !start_fall |=> soft_irq_req == 2'h0)
    else $error("request without start edge");

  // Both cores, both edges, each behind its own enable
  for (genvar k = 0; k < 2; k++) begin : g_soft
    soft_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
      (start_rise && start_cfg.rise_en[k]) || (start_fall && start_cfg.fall_en[k])
        |=> soft_irq_req[k])
      else $error("enabled start edge lost");
    soft_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
      !(start_rise && start_cfg.rise_en[k]) && !(start_fall && start_cfg.fall_en[k])
        |=> !soft_irq_req[k])
      else $error("request from a disabled start edge");
  end

  // Second synchroniser stage follows the first
  sync_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(start_sync_q) |-> $past(start_meta_q))
    else $error("start edge skipped a synchroniser stage");

endmodule // core_irq_state

// ---- dv/host_reg_model.sv ----
// Host register master model for the register port
`timescale 1ns/10ps
`include "core_irq_params.svh"

module host_reg_model (
  input  wire logic                   clk,
  output logic [`REG_ADDR_W-1:0]      reg_addr,
  output logic                        reg_wr,
  output logic                        reg_rd,
  output logic [`REG_DATA_W-1:0]      reg_wdata,
  input  wire logic [`REG_DATA_W-1:0] reg_rdata,
  input  wire logic                   reg_ack
);
  // ==========================================
  // Idle bus at time zero
  initial begin
    reg_addr  = '0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = '1;
  end

  // One access: one-cycle strobe, then a bounded wait for the acknowledge
  task automatic access(input logic wr, input logic [8:0] addr, input logic [15:0] wd,
                        output logic [15:0] rd, output logic ok);
    ok = 1'b0;
    rd = '0;
    @(posedge clk);
    reg_addr  <= addr;
    reg_wdata <= wd;
    reg_wr    <= wr;
    reg_rd    <= ~wr;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    reg_addr  <= ~addr;  // Released bus shows no stale value
    reg_wdata <= ~wd;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge clk);
      if (reg_ack === 1'b1) begin
        ok = 1'b1;
        rd = reg_rdata;
      end
    end
  endtask
endmodule // host_reg_model

// ---- dv/core_irq_state_tb_top.sv ----
// Self-checking testbench for the interrupt state and counter divider block
`timescale 1ns/10ps
`include "core_irq_params.svh"

module core_irq_state_tb_top;
  import core_irq_pkg::*;
  logic           clk, rst_n, reg_wr, reg_rd, reg_ack, start_pin, core_tick;
  logic [8:0]     reg_addr;
  logic [15:0]    reg_wdata, reg_rdata;
  logic [3:0]     count_tick;
  logic [1:0]     soft_irq_req;
  core_event_t    core_a_evt, core_b_evt;
  start_irq_cfg_t start_cfg;
  int             n_mismatch = 0;
  int             n_tests = 0;

  // ==========================================
  // Design and host model
  core_irq_state #(.CHANNEL(2)) i_core_irq_state (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .core_a_evt(core_a_evt),
    .core_b_evt(core_b_evt), .start_cfg(start_cfg), .start_pin(start_pin),
    .core_tick(core_tick), .count_tick(count_tick), .soft_irq_req(soft_irq_req));
  host_reg_model i_host_reg_model (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack));

  // ==========================================
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("Compares %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic acc(input logic wr, input logic [8:0] a, input logic [15:0] wd,
                     output logic [15:0] rd);
    logic ok;
    i_host_reg_model.access(wr, a, wd, rd, ok);
    if (!ok) begin
      n_mismatch++;
      $display("mismatch at %0t: no acknowledge", $time);
      end_sim();
    end
  endtask

  task automatic rd_chk(input logic [8:0] a, input logic [15:0] exp);
    logic [15:0] d;
    acc(1'b0, a, 16'h0000, d);
    check(d, exp);
  endtask

  // Pulse one event on core a (b=0) or core b (b=1)
  task automatic ev(input logic b, input logic en, input logic lv, input logic [2:0] s,
                    input logic ci, input logic cm, input logic [9:0] sq, input logic [9:0] br);
    @(posedge clk);
    if (b) core_b_evt <= {en, lv, s, ci, cm, sq, br};
    else core_a_evt <= {en, lv, s, ci, cm, sq, br};
    @(posedge clk);
    core_a_evt <= '0;
    core_b_evt <= '0;
  endtask

  // ==========================================
  // Scenarios
  task automatic test_regs();
    logic [15:0] d;
    rd_chk(`CORE0_STATE_CH2, 16'h0000);
    rd_chk(`CORE1_STATE_CH2, 16'h0000);
    rd_chk(`DIVIDER_CH2, 16'h0000);
    acc(1'b1, `CORE0_STATE_CH2, 16'h3FFF, d);
    rd_chk(`CORE0_STATE_CH2, 16'h0000);
    acc(1'b1, `DIVIDER_CH1, 16'hFFFF, d);
    rd_chk(`DIVIDER_CH2, 16'h0000);
    $display("test_regs done");
  endtask

  task automatic test_div();
    logic [15:0] d;
    logic [15:0] exp [4] = '{16'h0030, 16'h0010, 16'h0003, 16'h0008};
    int          cnt [4];
    acc(1'b1, `DIVIDER_CH2, 16'h5F20, d);
    rd_chk(`DIVIDER_CH2, 16'h5F20);
    for (int g = 0; g < 2; g++) begin
      @(posedge clk);
      core_tick <= (g == 0);
      repeat (20) @(posedge clk);
      cnt = '{default: 0};
      repeat (48) begin
        @(negedge clk);
        for (int i = 0; i < 4; i++) cnt[i] += count_tick[i];
      end
      for (int i = 0; i < 4; i++) check(16'(cnt[i]), g ? 16'h0000 : exp[i]);
    end
    core_tick <= 1'b1;
    $display("test_div done");
  endtask

  task automatic test_evt();
    for (int s = 0; s < 8; s++) begin
      ev(1'b0, 1'b1, 1'b0, 3'(s), 1'b0, 1'b1, 10'(16 * s + 3), 10'h3FF);
      rd_chk(`CORE0_STATE_CH2, {3'b001, 3'(s), 10'(16 * s + 3)});
    end
    ev(1'b0, 1'b1, 1'b0, 3'h1, 1'b1, 1'b1, 10'h100, 10'h2AB);
    rd_chk(`CORE0_STATE_CH2, 16'h26AB);
    ev(1'b0, 1'b1, 1'b0, 3'h2, 1'b1, 1'b0, 10'h155, 10'h2AB);
    rd_chk(`CORE0_STATE_CH2, 16'h2955);
    ev(1'b0, 1'b1, 1'b0, 3'h3, 1'b0, 1'b1, 10'h0AA, 10'h3FF);
    rd_chk(`CORE0_STATE_CH2, 16'h2CAA);
    rd_chk(`CORE1_STATE_CH2, 16'h0000);
    ev(1'b1, 1'b1, 1'b0, 3'h6, 1'b0, 1'b0, 10'h00F, 10'h3FF);
    ev(1'b0, 1'b0, 1'b1, 3'h0, 1'b0, 1'b0, 10'h000, 10'h000);
    rd_chk(`CORE0_STATE_CH2, 16'h0000);
    rd_chk(`CORE1_STATE_CH2, 16'h380F);
    ev(1'b1, 1'b0, 1'b1, 3'h0, 1'b0, 1'b0, 10'h000, 10'h000);
    rd_chk(`CORE1_STATE_CH2, 16'h0000);
    $display("test_evt done");
  endtask

  task automatic test_start();
    int r [2];
    start_cfg <= {2'b01, 2'b10};
    for (int k = 0; k < 2; k++) begin
      r = '{0, 0};
      @(posedge clk);
      start_pin <= (k == 0);
      repeat (8) begin
        @(negedge clk);
        r[0] += soft_irq_req[0];
        r[1] += soft_irq_req[1];
      end
      check(16'(r[0]), k ? 16'h0000 : 16'h0001);
      check(16'(r[1]), k ? 16'h0001 : 16'h0000);
    end
    $display("test_start done");
  endtask

  // Reset in mid-run clears divider and status, ticks run undivided
  task automatic test_reset();
    logic [15:0] d;
    int          n;
    acc(1'b1, `DIVIDER_CH2, 16'h1234, d);
    ev(1'b1, 1'b1, 1'b0, 3'h4, 1'b0, 1'b0, 10'h011, 10'h3FF);
    rd_chk(`CORE1_STATE_CH2, 16'h3011);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(`DIVIDER_CH2, 16'h0000);
    rd_chk(`CORE1_STATE_CH2, 16'h0000);
    n = 0;
    repeat (8) begin
      @(negedge clk);
      n += (count_tick == 4'hF);
    end
    check(16'(n), 16'h0008);
    $display("test_reset done");
  endtask

  // ==========================================
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Reset, then the scenarios in turn
  initial begin
    rst_n      = 1'b0;
    core_a_evt = '0;
    core_b_evt = '0;
    start_cfg  = '0;
    start_pin  = 1'b0;
    core_tick  = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    test_regs();
    test_div();
    test_evt();
    test_start();
    test_reset();
    end_sim();
  end
endmodule // core_irq_state_tb_top
